//--- logic/pcm_menu.sv
// panel configuration menu controller with avalon register slave
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "pcm_defs.svh"
module pcm_menu import pcm_pkg::*; #(
  parameter int unsigned P_MS_CYC = `PCM_MS_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire pcm_btn_t    i_btn,
  input  wire logic        i_seg_test_done,
  input  wire logic        i_relay_fitted,
  input  wire logic [15:0] i_meas_value,
  input  wire logic [15:0] i_ser_value,
  input  wire logic        i_ser_valid,
  input  wire logic        i_sys_init,
  input  wire logic        i_sw1,
  input  wire logic        i_alarm,
  input  wire logic        i_error,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic [15:0]      o_disp_value,
  output logic [2:0]       o_item,
  output logic [1:0]       o_menu_state,
  output logic [15:0]      o_edit_value,
  output logic             o_store,
  output logic [11:0]      o_dac,
  output logic             o_relay,
  output logic             o_serial_mode
);
  // ****************************************
  // button edges and millisecond tick
  // ****************************************
  pcm_btn_t    btn_q;
  pcm_btn_t    rise;
  logic        any_rise;
  logic [31:0] pre_q;
  logic        tick;
  assign rise     = i_btn & ~btn_q;
  assign any_rise = |rise;
  assign tick     = (pre_q == P_MS_CYC - 1);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) btn_q <= '0;
    else btn_q <= i_btn;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || tick) pre_q <= '0;
    else pre_q <= pre_q + 32'h1;
  end

  // ****************************************
  // item limits and sequence
  // ****************************************
  function automatic logic [15:0] item_max(input pcm_item_t it);
    unique case (it)
      IT_INP:  item_max = `PCM_INP_MAX;
      IT_ADDR: item_max = `PCM_ADDR_MAX;
      IT_DP:   item_max = `PCM_DP_MAX;
      IT_AERR: item_max = 16'h0001;
      IT_OUTF: item_max = `PCM_OUTF_MAX;
      default: item_max = `PCM_VAL_MAX;
    endcase
  endfunction : item_max

  function automatic pcm_item_t next_item(input pcm_item_t it, input logic ser);
    unique case (it)
      IT_INP:  next_item = ser ? IT_ADDR : IT_INP;
      IT_ADDR: next_item = IT_DP;
      IT_ALO:  next_item = IT_AHI;
      IT_AHI:  next_item = IT_AERR;
      IT_AERR: next_item = IT_ALO;
      IT_OUTF: next_item = IT_OUTF;
      default: next_item = IT_INP;
    endcase
  endfunction : next_item

  // ****************************************
  // stored parameters
  // ****************************************
  pcm_mstate_t st_q;
  pcm_item_t   item_q;
  logic [15:0] edit_q;
  logic [2:0]  inp_q;
  logic [7:0]  addr_q;
  logic [1:0]  dp_q;
  logic [15:0] alo_q;
  logic [15:0] ahi_q;
  logic        aerr_q;
  logic [1:0]  outf_q;
  logic [15:0] stored;
  logic        commit;
  logic        bus_wr;
  logic [15:0] wd;
  assign commit = (st_q == MS_SET) && rise.adv;
  assign wd     = i_avs_writedata[15:0];
  assign o_serial_mode = (inp_q == `PCM_INP_SERIAL);

  always_comb begin
    unique case (item_q)
      IT_INP:  stored = {13'h0000, inp_q};
      IT_ADDR: stored = {8'h00, addr_q};
      IT_DP:   stored = {14'h0000, dp_q};
      IT_ALO:  stored = alo_q;
      IT_AHI:  stored = ahi_q;
      IT_AERR: stored = {15'h0000, aerr_q};
      IT_OUTF: stored = {14'h0000, outf_q};
      default: stored = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      inp_q  <= 3'h0;
      addr_q <= `PCM_ADDR_RST;
      dp_q   <= 2'h0;
      alo_q  <= 16'h0000;
      ahi_q  <= 16'h03E8;
      aerr_q <= 1'b0;
      outf_q <= OF_NONE;
    end else if (i_sys_init) begin
      addr_q <= `PCM_ADDR_RST;
    end else if (commit) begin
      unique case (item_q)
        IT_INP:  inp_q  <= edit_q[2:0];
        IT_ADDR: addr_q <= edit_q[7:0];
        IT_DP:   dp_q   <= edit_q[1:0];
        IT_ALO:  alo_q  <= edit_q;
        IT_AHI:  ahi_q  <= edit_q;
        IT_AERR: aerr_q <= edit_q[0];
        IT_OUTF: outf_q <= edit_q[1:0];
        default: ;
      endcase
    end else if (bus_wr) begin
      unique case (i_avs_address)
        `PCM_REG_ADDR: if (wd <= `PCM_ADDR_MAX) addr_q <= wd[7:0];
        `PCM_REG_DP:   dp_q   <= wd[1:0];
        `PCM_REG_CTRL: inp_q  <= wd[2:0];
        `PCM_REG_ALO:  alo_q  <= wd;
        `PCM_REG_AHI:  ahi_q  <= wd;
        `PCM_REG_AERR: aerr_q <= wd[0];
        `PCM_REG_OUTF: if (wd <= `PCM_OUTF_MAX) outf_q <= wd[1:0];
        default: ;
      endcase
    end
  end
  assign o_store = commit;

  // ****************************************
  // hold timers: repeat, long press, idle
  // ****************************************
  logic        updn;
  logic [15:0] hold_ms_q;
  logic [15:0] rep_ms_q;
  logic        rep_step;
  logic [15:0] lp_ms_q;
  logic        lp_done_q;
  logic        combo;
  logic        long_fire;
  logic [15:0] idle_ms_q;
  assign updn  = i_btn.up ^ i_btn.dn;
  assign combo = i_btn.rear && i_btn.adv && i_seg_test_done;
  assign rep_step = tick && updn && (hold_ms_q >= `PCM_REPEAT_MS) &&
                    (rep_ms_q + 16'h1 >= ((hold_ms_q >= `PCM_REPEAT_MS + `PCM_FAST_MS) ?
                     16'(`PCM_FAST_STEP_MS) : 16'(`PCM_SLOW_STEP_MS)));
  assign long_fire = tick && combo && !lp_done_q && (lp_ms_q + 16'h1 > `PCM_LONG_MS);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !updn) begin
      hold_ms_q <= 16'h0000;
      rep_ms_q  <= 16'h0000;
    end else if (tick) begin
      if (hold_ms_q != 16'hFFFF) hold_ms_q <= hold_ms_q + 16'h1;
      if (rep_step || hold_ms_q < `PCM_REPEAT_MS) rep_ms_q <= 16'h0000;
      else rep_ms_q <= rep_ms_q + 16'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !combo) begin
      lp_ms_q   <= 16'h0000;
      lp_done_q <= 1'b0;
    end else if (tick) begin
      lp_ms_q <= lp_ms_q + 16'h1;
      if (long_fire) lp_done_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || any_rise || st_q == MS_CLOSED) idle_ms_q <= 16'h0000;
    else if (tick) idle_ms_q <= idle_ms_q + 16'h1;
  end

  // ****************************************
  // menu state and edit value
  // ****************************************
  logic set_idle;
  logic menu_idle;
  logic step_up;
  logic step_dn;
  assign set_idle  = (st_q == MS_SET) && (idle_ms_q > `PCM_SET_IDLE_MS);
  assign menu_idle = (st_q != MS_CLOSED) && (idle_ms_q > `PCM_MENU_IDLE_MS);
  assign step_up   = (rise.up && !i_btn.dn) || (rep_step && i_btn.up);
  assign step_dn   = (rise.dn && !i_btn.up) || (rep_step && i_btn.dn);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q   <= MS_CLOSED;
      item_q <= IT_INP;
    end else if (menu_idle) begin
      st_q <= MS_CLOSED;
    end else begin
      unique case (st_q)
        MS_CLOSED: begin
          if (long_fire) begin
            st_q   <= MS_VIEW;
            item_q <= i_relay_fitted ? IT_OUTF : IT_ALO;
          end else if (i_btn.adv && i_btn.up && rise.adv) begin
            st_q   <= MS_VIEW;
            item_q <= IT_INP;
          end
        end
        MS_VIEW: begin
          if (rise.cancel) st_q <= MS_CLOSED;
          else if (rise.adv && !i_btn.rear) item_q <= next_item(item_q, o_serial_mode);
          else if (rise.up || rise.dn) st_q <= MS_SET;
        end
        MS_SET: begin
          if (rise.adv || rise.cancel || set_idle) st_q <= MS_VIEW;
        end
        default: st_q <= MS_CLOSED;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      edit_q <= 16'h0000;
    end else if (st_q != MS_SET) begin
      edit_q <= stored;
      if (st_q == MS_VIEW && (rise.up || rise.dn)) begin
        if (rise.up) edit_q <= (stored >= item_max(item_q)) ? 16'h0000 : stored + 16'h1;
        else edit_q <= (stored == 16'h0000) ? item_max(item_q) : stored - 16'h1;
      end
    end else if (step_up) begin
      edit_q <= (edit_q >= item_max(item_q)) ? 16'h0000 : edit_q + 16'h1;
    end else if (step_dn) begin
      edit_q <= (edit_q == 16'h0000) ? item_max(item_q) : edit_q - 16'h1;
    end
  end
  assign o_item       = item_q;
  assign o_menu_state = st_q;
  assign o_edit_value = edit_q;

  // ****************************************
  // displayed value, analog output, relay
  // ****************************************
  logic [15:0] disp_q;
  logic [15:0] span;
  logic [27:0] num;
  logic [11:0] dac_d;
  assign span = ahi_q - alo_q;
  assign num  = 28'(disp_q - alo_q) * 28'(`PCM_DAC_FULL);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) disp_q <= 16'h0000;
    else if (!o_serial_mode) disp_q <= i_meas_value;
    else if (i_ser_valid) disp_q <= i_ser_value;
  end
  assign o_disp_value = disp_q;

  always_comb begin
    if (i_error) dac_d = aerr_q ? `PCM_DAC_OVER : 12'h000;
    else if (ahi_q <= alo_q || disp_q <= alo_q) dac_d = 12'h000;
    else if (disp_q >= ahi_q) dac_d = `PCM_DAC_FULL;
    else dac_d = 12'(num / 28'(span));
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_dac   <= 12'h000;
      o_relay <= 1'b0;
    end else begin
      o_dac <= dac_d;
      unique case (outf_q)
        OF_2P:    o_relay <= i_sw1;
        OF_ALARM: o_relay <= !i_alarm;
        default:  o_relay <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // avalon slave
  // ****************************************
  logic ack_q;
  logic req;
  assign req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && !ack_q;
  assign bus_wr = i_avs_write && ack_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) ack_q <= 1'b0;
    else ack_q <= req && !ack_q;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read && !ack_q) begin
      unique case (i_avs_address)
        `PCM_REG_CTRL: o_avs_readdata <= {29'h0, inp_q};
        `PCM_REG_STAT: o_avs_readdata <= {10'h000, edit_q, o_serial_mode, st_q, item_q};
        `PCM_REG_ADDR: o_avs_readdata <= {24'h0, addr_q};
        `PCM_REG_DP:   o_avs_readdata <= {30'h0, dp_q};
        `PCM_REG_ALO:  o_avs_readdata <= {16'h0, alo_q};
        `PCM_REG_AHI:  o_avs_readdata <= {16'h0, ahi_q};
        `PCM_REG_AERR: o_avs_readdata <= {31'h0, aerr_q};
        `PCM_REG_OUTF: o_avs_readdata <= {30'h0, outf_q};
        `PCM_REG_DISP: o_avs_readdata <= {16'h0, disp_q};
        `PCM_REG_DAC:  o_avs_readdata <= {20'h0, o_dac};
        default:       o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_ser_disp;
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_serial_mode && i_ser_valid) |=> (o_disp_value == $past(i_ser_value));
  endproperty
  a_ser_disp: assert property (p_ser_disp) else $error("serial value not shown");

  property p_addr_range;
    @(posedge i_clk) disable iff (!i_rst_n) addr_q <= 8'hEF;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address above limit");

  property p_init;
    @(posedge i_clk) disable iff (!i_rst_n) i_sys_init |=> addr_q == `PCM_ADDR_RST;
  endproperty
  a_init: assert property (p_init) else $error("address not reset by init");

  property p_commit;
    @(posedge i_clk) disable iff (!i_rst_n)
    (commit && !menu_idle && !i_sys_init) |=> (st_q == MS_VIEW && stored == $past(edit_q));
  endproperty
  a_commit: assert property (p_commit) else $error("commit failed");

  property p_cancel_view;
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_q == MS_VIEW && rise.cancel) |=> st_q == MS_CLOSED;
  endproperty
  a_cancel_view: assert property (p_cancel_view) else $error("cancel did not close");

  property p_cancel_set;
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_q == MS_SET && rise.cancel && !menu_idle) |=> st_q == MS_VIEW ##1 edit_q == stored;
  endproperty
  a_cancel_set: assert property (p_cancel_set) else $error("cancel did not discard");

  property p_wrap;
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_q == MS_SET && step_up && !rise.adv && !rise.cancel && !set_idle && !menu_idle
     && edit_q == item_max(item_q)) |=> edit_q == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to low limit");

  property p_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
    (st_q != MS_CLOSED && idle_ms_q > `PCM_MENU_IDLE_MS) |=> st_q == MS_CLOSED;
  endproperty
  a_idle: assert property (p_idle) else $error("menu not closed on idle");

  property p_err_out;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_error |=> o_dac == ($past(aerr_q) ? `PCM_DAC_OVER : 12'h000);
  endproperty
  a_err_out: assert property (p_err_out) else $error("error output wrong");

  property p_relay;
    @(posedge i_clk) disable iff (!i_rst_n)
    (outf_q == OF_ALARM) |=> o_relay == !$past(i_alarm);
  endproperty
  a_relay: assert property (p_relay) else $error("alarm relay not inverted");
endmodule : pcm_menu

//--- logic/pcm_defs.svh
// constants of the panel configuration menu controller
`ifndef PCM_DEFS_SVH
`define PCM_DEFS_SVH
`define PCM_CLK_MHZ      100
`define PCM_MS_CYC       (`PCM_CLK_MHZ * 1000)
`define PCM_REPEAT_MS    1000
`define PCM_FAST_MS      2000
`define PCM_SLOW_STEP_MS 200
`define PCM_FAST_STEP_MS 40
`define PCM_SET_IDLE_MS  10000
`define PCM_MENU_IDLE_MS 60000
`define PCM_LONG_MS      2000
`define PCM_ADDR_MAX     16'h00EF
`define PCM_ADDR_RST     8'h00
`define PCM_DP_MAX       16'h0003
`define PCM_INP_MAX      16'h0007
`define PCM_INP_SERIAL   3'h7
`define PCM_OUTF_MAX     16'h0002
`define PCM_VAL_MAX      16'hFFFF
`define PCM_DAC_FULL     12'hFA0
`define PCM_DAC_OVER     12'hFFF
`define PCM_REG_CTRL     6'h00
`define PCM_REG_STAT     6'h04
`define PCM_REG_ADDR     6'h08
`define PCM_REG_DP       6'h0C
`define PCM_REG_ALO      6'h10
`define PCM_REG_AHI      6'h14
`define PCM_REG_AERR     6'h18
`define PCM_REG_OUTF     6'h1C
`define PCM_REG_DISP     6'h20
`define PCM_REG_DAC      6'h24
`endif

//--- logic/pcm_pkg.sv
// types of the panel configuration menu controller
package pcm_pkg;
  typedef struct packed {
    logic rear;
    logic cancel;
    logic dn;
    logic up;
    logic adv;
  } pcm_btn_t;
  typedef enum logic [1:0] {
    MS_CLOSED = 2'b00,
    MS_VIEW   = 2'b01,
    MS_SET    = 2'b10
  } pcm_mstate_t;
  typedef enum logic [2:0] {
    IT_INP  = 3'b000,
    IT_ADDR = 3'b001,
    IT_DP   = 3'b010,
    IT_ALO  = 3'b011,
    IT_AHI  = 3'b100,
    IT_AERR = 3'b101,
    IT_OUTF = 3'b110
  } pcm_item_t;
  typedef enum logic [1:0] {
    OF_NONE  = 2'b00,
    OF_2P    = 2'b01,
    OF_ALARM = 2'b10
  } pcm_outf_t;
endpackage : pcm_pkg

//--- verif/pcm_panel.sv
// front panel buttons and serial bus master model
`timescale 1ns/100ps
module pcm_panel import pcm_pkg::*; (
  input  wire logic   i_clk,
  output pcm_btn_t    o_btn,
  output logic [15:0] o_ser_value,
  output logic        o_ser_valid,
  output logic        o_sys_init
);
  // ****************
  // operator actions
  // ****************
  initial begin
    o_btn = '0;
    o_ser_value = 16'h0000;
    o_ser_valid = 1'b0;
    o_sys_init = 1'b0;
  end
  task automatic drive(input logic [4:0] b);
    @(posedge i_clk);
    o_btn <= pcm_btn_t'(b);
  endtask : drive
  task automatic press(input logic [4:0] b);
    drive(b);
    repeat (3) @(posedge i_clk);
    o_btn <= '0;
  endtask : press
  // first button down, then the second joins and both stay for n cycles
  task automatic chord(input logic [4:0] first, input logic [4:0] all, input int n);
    drive(first);
    repeat (2) @(posedge i_clk);
    o_btn <= pcm_btn_t'(all);
    repeat (n) @(posedge i_clk);
    o_btn <= '0;
  endtask : chord
  // the value line shows no stale copy once the frame is over
  task automatic send(input logic [15:0] v);
    @(posedge i_clk);
    o_ser_value <= v;
    o_ser_valid <= 1'b1;
    @(posedge i_clk);
    o_ser_valid <= 1'b0;
    o_ser_value <= ~v;
  endtask : send
  task automatic init_pulse();
    @(posedge i_clk);
    o_sys_init <= 1'b1;
    @(posedge i_clk);
    o_sys_init <= 1'b0;
  endtask : init_pulse
endmodule : pcm_panel

//--- verif/pcm_menu_tb.sv
// self-checking bench of the panel configuration menu controller
`timescale 1ns/100ps
`include "pcm_defs.svh"
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t %s", $time, m); end end
module pcm_menu_tb import pcm_pkg::*; ;
  localparam logic [4:0] B_ADV = 5'h01, B_UP = 5'h02, B_DN = 5'h04, B_CAN = 5'h08, B_REAR = 5'h10;
  logic        clk, rst_n, seg_done, relay_fit, ser_valid, sys_init, sw1, alarm, err;
  logic        avs_rd, avs_wr, wreq, store, relay, smode;
  pcm_btn_t    btn;
  logic [15:0] meas, ser_value, disp, edit;
  logic [5:0]  avs_addr;
  logic [31:0] avs_wdata, rdata;
  logic [2:0]  item;
  logic [1:0]  mstate;
  logic [11:0] dac;
  int          n_fail, samples_checked, k;
  int          n_store = 0;
  // ****************
  // harness
  // ****************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (store === 1'b1) n_store++;
  pcm_panel u_pan (.i_clk(clk), .o_btn(btn), .o_ser_value(ser_value), .o_ser_valid(ser_valid),
    .o_sys_init(sys_init));
  pcm_menu #(.P_MS_CYC(1)) u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_btn(btn),
    .i_seg_test_done(seg_done), .i_relay_fitted(relay_fit), .i_meas_value(meas),
    .i_ser_value(ser_value), .i_ser_valid(ser_valid), .i_sys_init(sys_init), .i_sw1(sw1),
    .i_alarm(alarm), .i_error(err), .i_avs_address(avs_addr), .i_avs_read(avs_rd),
    .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_disp_value(disp), .o_item(item), .o_menu_state(mstate),
    .o_edit_value(edit), .o_store(store), .o_dac(dac), .o_relay(relay), .o_serial_mode(smode));
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // request held up to the rising edge that samples waitrequest low
  task automatic av(input logic w, input logic [5:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    @(posedge clk);
    avs_addr <= a;
    avs_wdata <= wd;
    avs_rd <= !w;
    avs_wr <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    rd = rdata;
    if (wreq !== 1'b0) begin
      n_fail++;
      results();
    end
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
  endtask : av
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    av(1'b1, a, d, x);
  endtask : wr
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] x;
    av(1'b0, a, 32'h0000_0000, x);
    `CHK(x, e, "register read");
  endtask : rc
  task automatic mc(input logic [1:0] s, input logic [2:0] it);
    @(negedge clk);
    `CHK(mstate, s, "menu state");
    if (s != MS_CLOSED) `CHK(item, it, "menu item");
  endtask : mc
  task automatic ec(input logic [15:0] e);
    @(negedge clk);
    `CHK(edit, e, "edit value");
  endtask : ec
  task automatic rl(input logic s, input logic a, input logic e);
    @(posedge clk);
    sw1 <= s;
    alarm <= a;
    tick(3);
    @(negedge clk);
    `CHK(relay, e, "relay");
  endtask : rl
  task automatic dc(input logic [15:0] m, input logic f, input logic [11:0] e);
    @(posedge clk);
    meas <= m;
    err <= f;
    tick(4);
    @(negedge clk);
    `CHK(dac, e, "analog code");
  endtask : dc
  // ****************
  // scenarios
  // ****************
  task automatic t_serial();
    rc(`PCM_REG_ADDR, 32'h0);
    rc(`PCM_REG_AHI, 32'h3E8);
    wr(6'h3C, 32'h1);
    rc(6'h3C, 32'h0);
    wr(`PCM_REG_CTRL, 32'h7);
    u_pan.send(16'h1234);
    tick(2);
    @(negedge clk);
    `CHK(smode, 1'b1, "serial mode");
    `CHK(disp, 16'h1234, "shown value");
    rc(`PCM_REG_DISP, 32'h1234);
    rc(`PCM_REG_STAT, 32'h1E0);
    wr(`PCM_REG_ADDR, 32'd240);
    rc(`PCM_REG_ADDR, 32'h0);
    wr(`PCM_REG_ADDR, 32'd239);
    rc(`PCM_REG_ADDR, 32'd239);
    u_pan.init_pulse();
    rc(`PCM_REG_ADDR, 32'h0);
    wr(`PCM_REG_ADDR, 32'd239);
  endtask : t_serial
  task automatic t_nav();
    u_pan.chord(B_UP, B_UP | B_ADV, 3);
    mc(MS_VIEW, IT_INP);
    u_pan.press(B_ADV);
    mc(MS_VIEW, IT_ADDR);
    u_pan.press(B_UP);
    mc(MS_SET, IT_ADDR);
    ec(16'h0000);
    k = n_store;
    u_pan.press(B_ADV);
    mc(MS_VIEW, IT_ADDR);
    `CHK(n_store, k + 1, "commit pulse");
    rc(`PCM_REG_ADDR, 32'h0);
    u_pan.press(B_DN);
    ec(16'h00EF);
    u_pan.press(B_CAN);
    mc(MS_VIEW, IT_ADDR);
    rc(`PCM_REG_ADDR, 32'h0);
    u_pan.press(B_UP);
    u_pan.press(B_UP);
    ec(16'h0002);
    u_pan.press(B_DN);
    ec(16'h0001);
    u_pan.press(B_CAN);
    u_pan.press(B_ADV);
    mc(MS_VIEW, IT_DP);
    u_pan.press(B_ADV);
    mc(MS_VIEW, IT_INP);
    u_pan.press(B_CAN);
    mc(MS_CLOSED, IT_INP);
  endtask : t_nav
  task automatic t_hold_idle();
    u_pan.chord(B_UP, B_UP | B_ADV, 3);
    u_pan.press(B_ADV);
    u_pan.drive(B_UP);
    tick(900);
    ec(16'h0001);
    tick(2700);
    @(negedge clk);
    `CHK(edit >= 16'd20 && edit <= 16'd32, 1'b1, "repeat count");
    u_pan.drive(5'h00);
    u_pan.press(B_CAN);
    rc(`PCM_REG_ADDR, 32'h0);
    u_pan.press(B_UP);
    tick(9800);
    mc(MS_SET, IT_ADDR);
    tick(400);
    mc(MS_VIEW, IT_ADDR);
    rc(`PCM_REG_ADDR, 32'h0);
    tick(49500);
    mc(MS_VIEW, IT_ADDR);
    tick(600);
    mc(MS_CLOSED, IT_INP);
  endtask : t_hold_idle
  task automatic t_menus();
    u_pan.chord(B_REAR, B_REAR | B_ADV, 2100);
    mc(MS_CLOSED, IT_INP);
    @(posedge clk);
    seg_done <= 1'b1;
    u_pan.chord(B_REAR, B_REAR | B_ADV, 1900);
    mc(MS_CLOSED, IT_INP);
    u_pan.chord(B_REAR, B_REAR | B_ADV, 2100);
    mc(MS_VIEW, IT_ALO);
    u_pan.press(B_ADV);
    mc(MS_VIEW, IT_AHI);
    u_pan.press(B_ADV);
    mc(MS_VIEW, IT_AERR);
    u_pan.press(B_ADV);
    mc(MS_VIEW, IT_ALO);
    u_pan.press(B_CAN);
    @(posedge clk);
    relay_fit <= 1'b1;
    u_pan.chord(B_REAR, B_REAR | B_ADV, 2100);
    mc(MS_VIEW, IT_OUTF);
    u_pan.press(B_UP);
    ec(16'h0001);
    u_pan.press(B_UP);
    u_pan.press(B_UP);
    ec(16'h0000);
    u_pan.press(B_DN);
    ec(16'h0002);
    u_pan.press(B_ADV);
    rc(`PCM_REG_OUTF, 32'h2);
    rl(1'b0, 1'b0, 1'b1);
    rl(1'b0, 1'b1, 1'b0);
    u_pan.press(B_CAN);
    wr(`PCM_REG_OUTF, 32'h1);
    rl(1'b1, 1'b0, 1'b1);
    rl(1'b0, 1'b1, 1'b0);
    wr(`PCM_REG_OUTF, 32'h0);
    rl(1'b1, 1'b0, 1'b0);
    wr(`PCM_REG_OUTF, 32'h3);
    rc(`PCM_REG_OUTF, 32'h0);
  endtask : t_menus
  task automatic t_dac();
    wr(`PCM_REG_CTRL, 32'h0);
    wr(`PCM_REG_ALO, 32'h0);
    wr(`PCM_REG_AHI, 32'd1000);
    // midway between the scales gives half of full scale
    dc(16'd500, 1'b0, 12'h7D0);
    dc(16'd1000, 1'b0, `PCM_DAC_FULL);
    dc(16'd0, 1'b0, 12'h000);
    wr(`PCM_REG_AERR, 32'h0);
    dc(16'd500, 1'b1, 12'h000);
    wr(`PCM_REG_AERR, 32'h1);
    dc(16'd500, 1'b1, `PCM_DAC_OVER);
  endtask : t_dac
  initial begin
    rst_n = 1'b0;
    seg_done = 1'b0;
    relay_fit = 1'b0;
    meas = 16'h5555;
    sw1 = 1'b0;
    alarm = 1'b0;
    err = 1'b0;
    avs_rd = 1'b0;
    avs_wr = 1'b0;
    avs_addr = 6'h00;
    avs_wdata = 32'h0000_0000;
    n_fail = 0;
    samples_checked = 0;
    tick(12);
    rst_n <= 1'b1;
    t_serial();
    t_nav();
    t_hold_idle();
    t_menus();
    t_dac();
    results();
  end
endmodule : pcm_menu_tb
